/* File: design/serial_pkg.sv */
// constants, field layout and shared decoding for the serial interface
// assumes a single 40 MHz clock and bus strobes sampled on that clock
//
// Summary of operation
// - two bus locations, four registers inside
// - pair select picks data or control pair
// - selected only when high, high, low
// - data bus driven only during reads
// - enable strobe gates buffers, moves data
// - hold reset until software master reset
// - start, data, parity, one or two stops
// - queued character follows automatically
// - divide one externally synced, others internal
// - timing starts at start bit edge
// - half bit of space before alignment
// - parity, framing, overrun, full in status
// - seven bits plus parity, top bit zero
// - receive data held while next arrives
// - interrupt low while enabled cause present
// - transmit bits launched on clock fall
// - receive line sampled on clock rise
// - divide bits select ratio or reset
// - receive full set, cleared by read
// - write clears transmit empty until moved
// - control bit seven enables receive interrupts
package serial_pkg;

  // -------------------------------------------------------------------
  // control register fields
  // -------------------------------------------------------------------
  localparam int         CTRL_DIV_LO    = 0;
  localparam int         CTRL_DIV_HI    = 1;
  localparam int         CTRL_WORD_LO   = 2;
  localparam int         CTRL_WORD_HI   = 4;
  localparam int         CTRL_TXC_LO    = 5;
  localparam int         CTRL_TXC_HI    = 6;
  localparam int         CTRL_RX_IE     = 7;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [1:0] DIV_BY_1       = 2'h0;
  localparam logic [1:0] DIV_BY_16      = 2'h1;
  localparam logic [1:0] DIV_BY_64      = 2'h2;
  localparam logic [1:0] DIV_MRESET     = 2'h3;
  localparam logic [1:0] TXC_RTS_IE     = 2'h1;
  localparam logic [1:0] TXC_RTS_OFF    = 2'h2;
  localparam logic [1:0] TXC_BREAK      = 2'h3;

  // -------------------------------------------------------------------
  // status register bit positions
  // -------------------------------------------------------------------
  localparam int STAT_RX_REGISTER_FULL = 0;
  localparam int STAT_TX_REGISTER_EMPTY = 1;
  localparam int STAT_DCD  = 2;
  localparam int STAT_CTS  = 3;
  localparam int STAT_FE   = 4;
  localparam int STAT_OVR  = 5;
  localparam int STAT_PE   = 6;
  localparam int STAT_IRQ  = 7;

  // -------------------------------------------------------------------
  // word format flags and sizes
  // -------------------------------------------------------------------
  localparam int         FMT_LEN8      = 3;
  localparam int         FMT_PAR_EN    = 2;
  localparam int         FMT_PAR_ODD   = 1;
  localparam int         FMT_TWO_STOP  = 0;
  localparam int         DATA_WIDTH    = 8;
  localparam int         TX_FIFO_DEPTH = 16;
  localparam logic [5:0] LAST_DIV_1    = 6'h00;
  localparam logic [5:0] LAST_DIV_16   = 6'h0f;
  localparam logic [5:0] LAST_DIV_64   = 6'h3f;

  // word select code to {len8, parity on, odd, two stops}
  function automatic logic [3:0] word_format(input logic [2:0] code);
    logic [3:0] f;
    f = 4'h0;
    unique case (code)
      3'h0: f = 4'b0101;
      3'h1: f = 4'b0111;
      3'h2: f = 4'b0100;
      3'h3: f = 4'b0110;
      3'h4: f = 4'b1001;
      3'h5: f = 4'b1000;
      3'h6: f = 4'b1100;
      3'h7: f = 4'b1110;
    endcase
    return f;
  endfunction

  // divide code to last count of the clock divider
  function automatic logic [5:0] div_last(input logic [1:0] code);
    logic [5:0] l;
    l = LAST_DIV_1;
    if (code == DIV_BY_16)
      l = LAST_DIV_16;
    else if (code == DIV_BY_64)
      l = LAST_DIV_64;
    return l;
  endfunction

endpackage

/* File: design/pin_edge.sv */
// edge detector for a pin sampled on the system clock
// assumes the pin is already synchronous to clock
`timescale 1ns/1ps
module pin_edge #(
  parameter logic REST_LEVEL = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic prev_r;

  // remember the last sample
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      prev_r <= REST_LEVEL;
    else
      prev_r <= level;
  end

  // one-cycle pulses on each change
  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

endmodule

/* File: design/byte_fifo.sv */
// first-in first-out buffer with valid and ready on both sides
// assumes one clock; flush empties it in one cycle
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = ~((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  // storage write
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr_r[AW-1:0]] <= in_data;
  end

  // pointers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else if (flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

endmodule

/* File: design/async_serial_comms_interface.sv */
// asynchronous serial communications interface: bus side, transmitter, receiver
// assumes all pins, including the bit clock pins, are synchronous to clock
`timescale 1ns/1ps
module async_serial_comms_interface #(
  parameter int FIFO_DEPTH = serial_pkg::TX_FIFO_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       chip_select_high_a,
  input  wire logic       chip_select_high_b,
  input  wire logic       chip_select_low,
  input  wire logic       register_pair_select,
  input  wire logic       read_write,
  input  wire logic       enable,
  input  wire logic [7:0] bus_data_lines_in,
  output logic      [7:0] bus_data_lines_out,
  output logic            bus_data_lines_oe,
  output logic            irq_n_out,
  output logic            irq_oe,
  input  wire logic       tx_clk,
  input  wire logic       rx_clk,
  input  wire logic       rx_data_line,
  output logic            tx_data_line,
  output logic            rts_n,
  input  wire logic       cts_n,
  input  wire logic       carrier_lost
);

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_START  = 3'b001,
    TX_DATA   = 3'b010,
    TX_PARITY = 3'b011,
    TX_STOP   = 3'b100
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } rx_state_e;

  // -------------------------------------------------------------------
  // bus access capture
  // -------------------------------------------------------------------
  logic       e_fall;
  logic       acc_sel_r;
  logic       acc_rs_r;
  logic       acc_rw_r;
  logic [7:0] acc_data_r;
  logic       sel_now;
  logic       strobe;
  logic       wr_ctrl;
  logic       wr_tx;
  logic       rd_stat;
  logic       rd_rx;

  pin_edge #(.REST_LEVEL(1'b0)) u_enable_edge (
    .clock (clock),
    .rst   (rst),
    .level (enable),
    .rise  (),
    .fall  (e_fall)
  );

  // device selected by two high selects and one low select
  assign sel_now = chip_select_high_a & chip_select_high_b & ~chip_select_low;

  // latch the access while enable is high, act on its falling edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      acc_sel_r  <= 1'b0;
      acc_rs_r   <= 1'b0;
      acc_rw_r   <= 1'b0;
      acc_data_r <= 8'h00;
    end
    else if (enable)
    begin
      acc_sel_r  <= sel_now;
      acc_rs_r   <= register_pair_select;
      acc_rw_r   <= read_write;
      acc_data_r <= bus_data_lines_in;
    end
  end

  // decode the four registers from pair select and direction
  assign strobe  = e_fall & acc_sel_r;
  assign wr_ctrl = strobe & ~acc_rs_r & ~acc_rw_r;
  assign wr_tx   = strobe & acc_rs_r & ~acc_rw_r;
  assign rd_stat = strobe & ~acc_rs_r & acc_rw_r;
  assign rd_rx   = strobe & acc_rs_r & acc_rw_r;

  // drivers on only while a selected read has enable high
  assign bus_data_lines_oe = enable & sel_now & read_write;

  // -------------------------------------------------------------------
  // control register and reset hold
  // -------------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic       por_hold_r;
  logic       master_reset;
  logic       divide_select_low;
  logic       divide_select_high;
  logic       tx_control_low;
  logic       tx_control_high;
  logic       rx_interrupt_enable;
  logic [1:0] div_code;
  logic [1:0] tx_ctrl;
  logic [5:0] last_cnt;
  logic [3:0] fmt;

  // control register write
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ctrl_r <= serial_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_r <= acc_data_r;
  end

  // power-up hold released only by a master reset command
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      por_hold_r <= 1'b1;
    else if (wr_ctrl && acc_data_r[serial_pkg::CTRL_DIV_HI:serial_pkg::CTRL_DIV_LO]
             == serial_pkg::DIV_MRESET)
      por_hold_r <= 1'b0;
  end

  assign divide_select_low   = ctrl_r[serial_pkg::CTRL_DIV_LO];
  assign divide_select_high  = ctrl_r[serial_pkg::CTRL_DIV_HI];
  assign tx_control_low      = ctrl_r[serial_pkg::CTRL_TXC_LO];
  assign tx_control_high     = ctrl_r[serial_pkg::CTRL_TXC_HI];
  assign rx_interrupt_enable = ctrl_r[serial_pkg::CTRL_RX_IE];
  assign div_code            = {divide_select_high, divide_select_low};
  assign tx_ctrl             = {tx_control_high, tx_control_low};
  assign master_reset        = por_hold_r | (div_code == serial_pkg::DIV_MRESET);
  assign last_cnt            = serial_pkg::div_last(div_code);
  assign fmt = serial_pkg::word_format(ctrl_r[serial_pkg::CTRL_WORD_HI:serial_pkg::CTRL_WORD_LO]);

  // -------------------------------------------------------------------
  // transmitter
  // -------------------------------------------------------------------
  logic       tx_fall;
  logic       tx_tick;
  logic [5:0] tx_div_r;
  logic       q_valid;
  logic       q_ready;
  logic [7:0] q_data;
  logic       tx_load;
  tx_state_e  tx_state_r;
  logic [7:0] tx_shift_r;
  logic [2:0] tx_bit_r;
  logic       tx_par_r;
  logic       tx_line_r;
  logic       tx_out_r;
  logic       tx_empty;

  pin_edge #(.REST_LEVEL(1'b0)) u_tx_clk_edge (
    .clock (clock),
    .rst   (rst),
    .level (tx_clk),
    .rise  (),
    .fall  (tx_fall)
  );

  // transmit data register: written characters queue here
  byte_fifo #(.WIDTH(serial_pkg::DATA_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clock     (clock),
    .rst       (rst),
    .flush     (master_reset),
    .in_valid  (wr_tx),
    .in_ready  (q_ready),
    .in_data   (acc_data_r),
    .out_valid (q_valid),
    .out_ready (tx_load),
    .out_data  (q_data)
  );

  // bit rate divider on falling edges of the transmit clock
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      tx_div_r <= 6'h00;
    else if (master_reset)
      tx_div_r <= 6'h00;
    else if (tx_fall)
      tx_div_r <= (tx_div_r >= last_cnt) ? 6'h00 : tx_div_r + 6'h01;
  end

  assign tx_tick = tx_fall & (tx_div_r >= last_cnt);
  // a queued character is taken at the end of the last stop bit
  assign tx_load = tx_tick & q_valid & ~master_reset & ((tx_state_r == TX_IDLE)
                   | ((tx_state_r == TX_STOP) & (~fmt[serial_pkg::FMT_TWO_STOP]
                   | (tx_bit_r != 3'h0))));
  assign tx_empty = ~q_valid;

  // frame sequencer: start, data lsb first, parity, stops
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 8'h00;
      tx_bit_r   <= 3'h0;
      tx_par_r   <= 1'b0;
      tx_line_r  <= 1'b1;
    end
    else if (master_reset)
    begin
      tx_state_r <= TX_IDLE;
      tx_bit_r   <= 3'h0;
      tx_line_r  <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_state_r <= TX_START;
      tx_shift_r <= q_data;
      tx_bit_r   <= 3'h0;
      tx_par_r   <= 1'b0;
      tx_line_r  <= 1'b0;
    end
    else if (tx_tick)
    begin
      unique case (tx_state_r)
        TX_IDLE:
          tx_line_r <= 1'b1;
        TX_START:
        begin
          tx_line_r  <= tx_shift_r[0];
          tx_par_r   <= tx_shift_r[0];
          tx_shift_r <= {1'b0, tx_shift_r[7:1]};
          tx_state_r <= TX_DATA;
        end
        TX_DATA:
        begin
          if (tx_bit_r == (fmt[serial_pkg::FMT_LEN8] ? 3'h7 : 3'h6))
          begin
            tx_bit_r <= 3'h0;
            if (fmt[serial_pkg::FMT_PAR_EN])
            begin
              tx_line_r  <= tx_par_r ^ fmt[serial_pkg::FMT_PAR_ODD];
              tx_state_r <= TX_PARITY;
            end
            else
            begin
              tx_line_r  <= 1'b1;
              tx_state_r <= TX_STOP;
            end
          end
          else
          begin
            tx_line_r  <= tx_shift_r[0];
            tx_par_r   <= tx_par_r ^ tx_shift_r[0];
            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
            tx_bit_r   <= tx_bit_r + 3'h1;
          end
        end
        TX_PARITY:
        begin
          tx_line_r  <= 1'b1;
          tx_state_r <= TX_STOP;
        end
        TX_STOP:
        begin
          if (fmt[serial_pkg::FMT_TWO_STOP] && tx_bit_r == 3'h0)
            tx_bit_r <= 3'h1;
          else
            tx_state_r <= TX_IDLE;
        end
        default:
        begin
          tx_state_r <= TX_IDLE;
          tx_line_r  <= 1'b1;
        end
      endcase
    end
  end

  // line driver with break, and request to send
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tx_out_r <= 1'b1;
      rts_n    <= 1'b1;
    end
    else if (por_hold_r)
    begin
      tx_out_r <= 1'b1;
      rts_n    <= 1'b1;
    end
    else
    begin
      tx_out_r <= (tx_ctrl == serial_pkg::TXC_BREAK) ? 1'b0 : tx_line_r;
      rts_n    <= (tx_ctrl == serial_pkg::TXC_RTS_OFF);
    end
  end

  assign tx_data_line = tx_out_r;

  // -------------------------------------------------------------------
  // receiver
  // -------------------------------------------------------------------
  logic       rx_rise;
  logic       carrier_rise;
  logic       rx_reset;
  logic       rx_sample;
  logic       rx_done;
  rx_state_e  rx_state_r;
  logic [5:0] rx_cnt_r;
  logic [7:0] rx_shift_r;
  logic [2:0] rx_bit_r;
  logic       rx_par_r;
  logic       rx_perr_r;

  pin_edge #(.REST_LEVEL(1'b0)) u_rx_clk_edge (
    .clock (clock),
    .rst   (rst),
    .level (rx_clk),
    .rise  (rx_rise),
    .fall  ()
  );

  pin_edge #(.REST_LEVEL(1'b0)) u_carrier_edge (
    .clock (clock),
    .rst   (rst),
    .level (carrier_lost),
    .rise  (carrier_rise),
    .fall  ()
  );

  assign rx_reset  = master_reset | carrier_lost;
  assign rx_sample = rx_rise & (rx_cnt_r == last_cnt);
  assign rx_done   = rx_sample & (rx_state_r == RX_STOP) & ~rx_reset;

  // start hunt, half bit qualification and mid-bit sampling
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r   <= 6'h00;
      rx_shift_r <= 8'h00;
      rx_bit_r   <= 3'h0;
      rx_par_r   <= 1'b0;
      rx_perr_r  <= 1'b0;
    end
    else if (rx_reset)
    begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r   <= 6'h00;
    end
    else if (rx_rise)
    begin
      unique case (rx_state_r)
        RX_IDLE:
        begin
          rx_cnt_r <= 6'h00;
          rx_bit_r <= 3'h0;
          rx_par_r <= 1'b0;
          if (!rx_data_line)
            // divide by one trusts external alignment
            rx_state_r <= (last_cnt == 6'h00) ? RX_DATA : RX_START;
        end
        RX_START:
        begin
          if (rx_data_line)
            rx_state_r <= RX_IDLE;
          else if (rx_cnt_r == (last_cnt >> 1))
          begin
            rx_cnt_r   <= 6'h00;
            rx_state_r <= RX_DATA;
          end
          else
            rx_cnt_r <= rx_cnt_r + 6'h01;
        end
        default:
        begin
          if (rx_cnt_r != last_cnt)
            rx_cnt_r <= rx_cnt_r + 6'h01;
          else
          begin
            rx_cnt_r <= 6'h00;
            if (rx_state_r == RX_DATA)
            begin
              rx_shift_r <= {rx_data_line, rx_shift_r[7:1]};
              rx_par_r   <= rx_par_r ^ rx_data_line;
              rx_bit_r   <= rx_bit_r + 3'h1;
              if (rx_bit_r == (fmt[serial_pkg::FMT_LEN8] ? 3'h7 : 3'h6))
                rx_state_r <= fmt[serial_pkg::FMT_PAR_EN] ? RX_PARITY : RX_STOP;
            end
            else if (rx_state_r == RX_PARITY)
            begin
              rx_perr_r  <= rx_par_r ^ rx_data_line ^ fmt[serial_pkg::FMT_PAR_ODD];
              rx_state_r <= RX_STOP;
            end
            else
              rx_state_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // status flags and receive data register
  // -------------------------------------------------------------------
  logic [7:0] rx_data_r;
  logic       rx_register_full_r;
  logic       overrun_r;
  logic       framing_r;
  logic       parity_r;
  logic       dcd_flag_r;
  logic       stat_seen_r;
  logic       rx_register_full;
  logic       tx_register_empty;
  logic       dcd_bit;
  logic       irq_cause;
  logic [7:0] status;

  // completed character moves over only into an empty register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_data_r <= 8'h00;
      framing_r <= 1'b0;
      parity_r  <= 1'b0;
    end
    else if (master_reset)
    begin
      framing_r <= 1'b0;
      parity_r  <= 1'b0;
    end
    else if (rx_done && !rx_register_full_r)
    begin
      rx_data_r <= fmt[serial_pkg::FMT_LEN8] ? rx_shift_r : {1'b0, rx_shift_r[7:1]};
      framing_r <= ~rx_data_line;
      parity_r  <= rx_perr_r & fmt[serial_pkg::FMT_PAR_EN];
    end
  end

  // full and overrun flags; a new event wins over a clearing read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_register_full_r    <= 1'b0;
      overrun_r <= 1'b0;
    end
    else if (master_reset)
    begin
      rx_register_full_r    <= 1'b0;
      overrun_r <= 1'b0;
    end
    else
    begin
      if (rx_done && !rx_register_full_r)
        rx_register_full_r <= 1'b1;
      else if (rd_rx)
        rx_register_full_r <= 1'b0;
      if (rx_done && rx_register_full_r)
        overrun_r <= 1'b1;
      else if (rd_rx)
        overrun_r <= 1'b0;
    end
  end

  // carrier loss latch, cleared by status read then data read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dcd_flag_r  <= 1'b0;
      stat_seen_r <= 1'b0;
    end
    else if (master_reset)
    begin
      dcd_flag_r  <= 1'b0;
      stat_seen_r <= 1'b0;
    end
    else
    begin
      if (carrier_rise)
        dcd_flag_r <= 1'b1;
      else if (rd_rx && stat_seen_r)
        dcd_flag_r <= 1'b0;
      if (rd_stat)
        stat_seen_r <= 1'b1;
      else if (rd_rx)
        stat_seen_r <= 1'b0;
    end
  end

  assign rx_register_full  = rx_register_full_r & ~carrier_lost;
  assign tx_register_empty = tx_empty & ~cts_n;
  assign dcd_bit           = dcd_flag_r | carrier_lost;
  assign irq_cause = (rx_interrupt_enable & (rx_register_full | dcd_bit))
                   | ((tx_ctrl == serial_pkg::TXC_RTS_IE) & tx_register_empty);

  always_comb
  begin
    status                        = 8'h00;
    status[serial_pkg::STAT_RX_REGISTER_FULL] = rx_register_full;
    status[serial_pkg::STAT_TX_REGISTER_EMPTY] = tx_register_empty;
    status[serial_pkg::STAT_DCD]  = dcd_bit;
    status[serial_pkg::STAT_CTS]  = cts_n;
    status[serial_pkg::STAT_FE]   = framing_r;
    status[serial_pkg::STAT_OVR]  = overrun_r;
    status[serial_pkg::STAT_PE]   = parity_r;
    status[serial_pkg::STAT_IRQ]  = irq_cause;
  end

  // read data and interrupt drive, both from flip-flops
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bus_data_lines_out <= 8'h00;
      irq_oe             <= 1'b0;
    end
    else
    begin
      bus_data_lines_out <= register_pair_select ? rx_data_r : status;
      irq_oe             <= irq_cause & ~por_hold_r;
    end
  end

  assign irq_n_out = 1'b0; // open drain: only ever pulls low

endmodule

/* File: test/serial_line_model.sv */
// far end: loops the transmit line back and makes the bit clock
// assumes the receiver shares this bit clock; it free-runs like a baud oscillator
`timescale 1ns/1ps
module serial_line_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic line_in,
  output logic      bit_clk,
  output logic      line_out
);
  logic [1:0] div_r;
  // ---
  // bit clock of four system clocks
  // ---
  always_ff @(posedge clock or posedge rst)
    if (rst)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  assign bit_clk = div_r[1];
  assign line_out = line_in;
endmodule

/* File: test/serial_asserts.sv */
// checks on bus drivers, interrupt pin and power-up hold
// assumes it is bound onto the interface top
`timescale 1ns/1ps
module serial_asserts (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       chip_select_high_a,
  input wire logic       chip_select_high_b,
  input wire logic       chip_select_low,
  input wire logic       register_pair_select,
  input wire logic       read_write,
  input wire logic       enable,
  input wire logic [7:0] bus_data_lines_in,
  input wire logic       bus_data_lines_oe,
  input wire logic       irq_n_out,
  input wire logic       irq_oe,
  input wire logic       tx_data_line,
  input wire logic       rts_n
);
  // ---
  // control write tracking
  // ---
  logic       sel;
  logic       wctl;
  logic       seen_r;
  logic       wc_r;
  logic [7:0] cd_r;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  assign sel = chip_select_high_a & chip_select_high_b & ~chip_select_low;
  assign wctl = enable & sel & ~register_pair_select & ~read_write;
  // remember master reset and the last control write under the strobe
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      seen_r <= 1'b0;
      wc_r <= 1'b0;
      cd_r <= 8'h00;
    end
    else if (enable)
    begin
      seen_r <= seen_r | (wctl & (bus_data_lines_in[1:0] == 2'b11));
      wc_r <= wctl;
      cd_r <= bus_data_lines_in;
    end
  oe_read_only_a: assert property (!read_write |-> !bus_data_lines_oe)
    else $error("bus driven in a write");
  oe_strobe_a: assert property (!enable |-> !bus_data_lines_oe)
    else $error("bus driven without strobe");
  oe_select_a: assert property (enable && read_write |-> bus_data_lines_oe == sel)
    else $error("bus drive ignores select");
  irq_drive_a: assert property (irq_oe |-> !irq_n_out)
    else $error("interrupt pin not pulled low");
  hold_tx_a: assert property (!seen_r |-> tx_data_line)
    else $error("line moved before master reset");
  hold_rts_a: assert property (!seen_r |-> rts_n)
    else $error("rts moved before master reset");
  hold_irq_a: assert property (!seen_r |-> !irq_oe)
    else $error("interrupt before master reset");
  rts_follow_a: assert property ($fell(enable) && wc_r && seen_r && cd_r[1:0] != 2'b11
    |-> ##2 rts_n == (cd_r[6:5] == 2'b10)) else $error("rts not from control");
  cover property (irq_oe);
  cover property (bus_data_lines_oe && register_pair_select);
  cover property ($fell(enable) && wc_r && seen_r);
endmodule
bind async_serial_comms_interface serial_asserts u_chk (.*);

/* File: test/async_serial_comms_interface_bench.sv */
// bus-level tests against a loopback far end
// assumes one shared bit clock; runs divide-by-1 and divide-by-16
`timescale 1ns/1ps
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module async_serial_comms_interface_bench;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       chip_select_high_a = 1'b1;
  logic       chip_select_high_b = 1'b1;
  logic       chip_select_low = 1'b0;
  logic       register_pair_select = 1'b0;
  logic       read_write = 1'b0;
  logic       enable = 1'b0;
  logic [7:0] bus_data_lines_in = 8'h00;
  logic       cts_n = 1'b0;
  logic       carrier_lost = 1'b0;
  logic       tx_clk, rx_clk, rx_data_line, bus_data_lines_oe, irq_n_out, irq_oe;
  logic       tx_data_line, rts_n;
  logic [7:0] bus_data_lines_out, q;
  int         failures = 0;
  int         cmp_count = 0;
  // ---
  // clock, design and far end
  // ---
  always #12.5 clock = ~clock;
  assign rx_clk = tx_clk;
  async_serial_comms_interface u_dut (.*);
  serial_line_model u_far (.clock(clock), .rst(rst), .line_in(tx_data_line),
                           .bit_clk(tx_clk), .line_out(rx_data_line));
  // one access; read data taken while the strobe is high
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d);
    @(posedge clock);
    register_pair_select <= rs;
    read_write <= rw;
    bus_data_lines_in <= d;
    enable <= 1'b1;
    repeat (2) @(posedge clock);
    q = bus_data_lines_out;
    enable <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // poll status until all bits of m are set, bounded
  task automatic wait_stat(input logic [7:0] m);
    int n;
    n = 0;
    do
    begin
      acc(1'b0, 1'b1, 8'h00);
      n++;
    end
    while ((q & m) !== m && n < 300);
  endtask
  task automatic final_report;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    `CHECK({tx_data_line, rts_n, irq_oe}, 3'b110)
    acc(1'b0, 1'b0, 8'h03);
    acc(1'b0, 1'b0, 8'h14);
    `CHECK(rts_n, 1'b0)
    chip_select_low <= 1'b1;
    acc(1'b1, 1'b0, 8'h66);
    chip_select_low <= 1'b0;
    repeat (60) @(posedge clock);
    acc(1'b0, 1'b1, 8'h00);
    `CHECK(q, 8'h02)
    acc(1'b1, 1'b0, 8'ha5);
    wait_stat(8'h01);
    `CHECK(q, 8'h03)
    acc(1'b1, 1'b1, 8'h00);
    `CHECK(q, 8'ha5)
    for (int i = 0; i < 16; i++)
      acc(1'b1, 1'b0, 8'h40 + 8'(i));
    wait_stat(8'h22);
    repeat (60) @(posedge clock);
    `CHECK(q, 8'h23)
    acc(1'b1, 1'b1, 8'h00);
    `CHECK(q, 8'h40)
    acc(1'b0, 1'b1, 8'h00);
    `CHECK(q, 8'h02)
    acc(1'b0, 1'b0, 8'h08);
    acc(1'b1, 1'b0, 8'hff);
    wait_stat(8'h01);
    acc(1'b1, 1'b1, 8'h00);
    `CHECK(q, 8'h7f)
    acc(1'b0, 1'b0, 8'h94);
    acc(1'b1, 1'b0, 8'h3c);
    wait_stat(8'h01);
    `CHECK(q, 8'h83)
    `CHECK(irq_oe, 1'b1)
    acc(1'b1, 1'b1, 8'h00);
    `CHECK(q, 8'h3c)
    // interrupt drive is registered: let the clear reach the pin
    @(posedge clock);
    `CHECK(irq_oe, 1'b0)
    `CHECK(tx_data_line, 1'b1)
    // divide-by-16 with request to send off
    acc(1'b0, 1'b0, 8'h55);
    acc(1'b1, 1'b0, 8'hc3);
    wait_stat(8'h01);
    `CHECK(rts_n, 1'b1)
    acc(1'b1, 1'b1, 8'h00);
    `CHECK(q, 8'hc3)
    final_report;
  end
  // watchdog: the tests need about 2000 clocks
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    final_report;
  end
endmodule
